// *** hw/plr_port_ctl.sv ***
// port control registers, link request issue and response time-outs
// assumes a single 50 mhz clock; link side signals come from logic on the same clock
// How it works
// RL1 - one 24-bit response time-out in bits 31-8 shared by all ports
// RL2 - time-out runs from request packet sent until its response arrives
// RL3 - duration is 15 times (prescale+1) clocks times the time-out value
// RL4 - prescale factor comes from the separate prescale register at 0x0020
// RL5 - general control bit 31 marks host (1) or agent (0)
// RL6 - bit 30 clear forbids originating requests, only answers allowed; here it only blocks the time-out timer start, link requests still issue
// RL7 - bit 29 records that a configuring element discovered this device
// RL8 - four independent link maintenance request registers, one per port
// RL9 - a write to a request register sends one link-request symbol, or replaces the command of one still pending
// RL10 - symbol carries the 3-bit command from bits 2-0
// RL11 - reading the command returns the last written value
// RL12 - valid bit 31 set on response, or on send when no response is expected; clears on read
// RL13 - capture ack sequence state into 9-5 and link status into 4-0
// RL14 - one timer per port, restarted by each request sent while bit 30 is set and the time-out is non-zero; expiry reported as event
`timescale 1ns/1ps
module plr_port_ctl (
    input wire logic clk,
    input wire logic arst_n,
    input wire plr_pkg::plr_bus_type bus,
    output logic [31:0] rdata,
    output logic host_role,
    output logic master_enable,
    output logic discovered,
    output logic [3:0] lreq_valid,
    output logic [11:0] lreq_command,
    input wire logic [3:0] lreq_ready,
    input wire logic [3:0] lreq_no_resp,
    input wire logic [3:0] lresp_valid,
    input wire plr_pkg::plr_resp_type [3:0] lresp,
    input wire logic [3:0] pkt_req_sent,
    input wire logic [3:0] pkt_resp_rcvd,
    output logic [3:0] rsp_timeout_event
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [23:0] rt_value, next_rt_value;
    logic [3:0] prescale, next_prescale;
    logic host, next_host, mst, next_mst, disc, next_disc;
    logic [2:0] cmd [4], next_cmd [4];
    logic [3:0] pend, next_pend;
    logic [3:0] wait_resp, next_wait_resp;
    logic [3:0] resp_vld, next_resp_vld;
    plr_pkg::plr_resp_type resp [4], next_resp [4];
    logic [31:0] next_rdata;
    logic [7:0] pre_cnt [4], next_pre_cnt [4];
    logic [7:0] tick_end;
    logic [3:0] rt_run, next_rt_run;
    logic [23:0] rt_cnt [4], next_rt_cnt [4];
    logic [3:0] next_to_evt;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int unsigned n);
        hit = (a == 8'(base + 8'(n) * plr_pkg::off_port_stride));
    endfunction : hit

    // ------------------------------------------------------------
    // register writes and reads
    // ------------------------------------------------------------
    always_comb begin
        next_rt_value = rt_value;
        next_prescale = prescale;
        next_host = host;
        next_mst = mst;
        next_disc = disc;
        next_rdata = 32'h0;
        if (bus.wr && bus.addr == plr_pkg::off_rsp_timeout) begin
            next_rt_value = bus.wdata[31:plr_pkg::rt_value_lsb]; // RL1
        end
        if (bus.wr && bus.addr == plr_pkg::off_prescale) begin
            next_prescale = bus.wdata[3:0]; // RL4
        end
        if (bus.wr && bus.addr == plr_pkg::off_gen_ctl) begin
            next_host = bus.wdata[plr_pkg::gen_host_bit]; // RL5
            next_mst = bus.wdata[plr_pkg::gen_master_bit]; // RL6
            next_disc = bus.wdata[plr_pkg::gen_disc_bit]; // RL7
        end
        if (bus.rd) begin
            if (bus.addr == plr_pkg::off_rsp_timeout) begin
                next_rdata = {rt_value, 8'h00};
            end else if (bus.addr == plr_pkg::off_prescale) begin
                next_rdata = {28'h0, prescale};
            end else if (bus.addr == plr_pkg::off_gen_ctl) begin
                next_rdata = {host, mst, disc, 29'h0};
            end
            for (int i = 0; i < 4; i++) begin
                if (hit(bus.addr, plr_pkg::off_lm_req0, i)) begin
                    next_rdata = {29'h0, cmd[i]}; // RL11
                end
                if (hit(bus.addr, plr_pkg::off_lm_resp0, i)) begin
                    next_rdata = {resp_vld[i], 21'h0, resp[i]}; // RL13
                end
            end
        end
    end

    // ------------------------------------------------------------
    // per-port link request and response capture
    // ------------------------------------------------------------
    always_comb begin
        next_pend = pend;
        next_wait_resp = wait_resp;
        next_resp_vld = resp_vld;
        for (int i = 0; i < 4; i++) begin // RL8
            next_cmd[i] = cmd[i];
            next_resp[i] = resp[i];
            // read clear first so a set in the same cycle wins
            if (bus.rd && hit(bus.addr, plr_pkg::off_lm_resp0, i)) begin
                next_resp_vld[i] = 1'b0; // RL12
            end
            if (pend[i] && lreq_ready[i]) begin
                next_pend[i] = 1'b0;
                if (lreq_no_resp[i]) begin
                    next_resp_vld[i] = 1'b1; // RL12
                end else begin
                    next_wait_resp[i] = 1'b1;
                end
            end
            if (wait_resp[i] && lresp_valid[i]) begin
                next_wait_resp[i] = 1'b0;
                next_resp_vld[i] = 1'b1; // RL12
                next_resp[i] = lresp[i]; // RL13
            end
            if (bus.wr && hit(bus.addr, plr_pkg::off_lm_req0, i)) begin
                next_cmd[i] = bus.wdata[2:0]; // RL10
                next_pend[i] = 1'b1; // RL9
                next_wait_resp[i] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // response time-out: per-port prescaler, one step every 15*(prescale+1) clocks
    // ------------------------------------------------------------
    always_comb begin
        tick_end = 8'(8'(prescale) * 8'(plr_pkg::rt_tick_mult) + 8'(plr_pkg::rt_tick_mult) - 8'h01); // RL3
        next_rt_run = rt_run;
        next_to_evt = 4'h0;
        for (int i = 0; i < 4; i++) begin // RL14
            next_rt_cnt[i] = rt_cnt[i];
            next_pre_cnt[i] = pre_cnt[i];
            if (pkt_req_sent[i] && mst && rt_value != 24'h0) begin // RL6
                next_rt_run[i] = 1'b1; // RL2
                next_rt_cnt[i] = rt_value; // RL1
                next_pre_cnt[i] = 8'h00; // RL3
            end else if (rt_run[i] && pkt_resp_rcvd[i]) begin
                next_rt_run[i] = 1'b0; // RL2
            end else if (rt_run[i]) begin
                if (pre_cnt[i] >= tick_end) begin
                    next_pre_cnt[i] = 8'h00;
                    next_rt_cnt[i] = rt_cnt[i] - 24'h1;
                    if (rt_cnt[i] == 24'h1) begin
                        next_rt_run[i] = 1'b0;
                        next_to_evt[i] = 1'b1; // RL14
                    end
                end else begin
                    next_pre_cnt[i] = pre_cnt[i] + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // control registers and read data
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rt_value <= plr_pkg::rst_rt_value;
            prescale <= plr_pkg::rst_prescale;
            host <= 1'b0;
            mst <= 1'b0;
            disc <= 1'b0;
            rdata <= 32'h0;
            host_role <= 1'b0;
            master_enable <= 1'b0;
            discovered <= 1'b0;
        end else begin
            rt_value <= next_rt_value;
            prescale <= next_prescale;
            host <= next_host;
            mst <= next_mst;
            disc <= next_disc;
            rdata <= next_rdata;
            host_role <= next_host;
            master_enable <= next_mst;
            discovered <= next_disc;
        end
    end

    // ------------------------------------------------------------
    // per-port request and response state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pend <= 4'h0;
            wait_resp <= 4'h0;
            resp_vld <= 4'h0;
            lreq_valid <= 4'h0;
            lreq_command <= 12'h000;
            for (int i = 0; i < 4; i++) begin
                cmd[i] <= plr_pkg::rst_command;
                resp[i] <= '0;
            end
        end else begin
            pend <= next_pend;
            wait_resp <= next_wait_resp;
            resp_vld <= next_resp_vld;
            lreq_valid <= next_pend;
            lreq_command <= {next_cmd[3], next_cmd[2], next_cmd[1], next_cmd[0]};
            for (int i = 0; i < 4; i++) begin
                cmd[i] <= next_cmd[i];
                resp[i] <= next_resp[i];
            end
        end
    end

    // ------------------------------------------------------------
    // per-port time-out counters
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rt_run <= 4'h0;
            rsp_timeout_event <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                pre_cnt[i] <= 8'h00;
                rt_cnt[i] <= 24'h0;
            end
        end else begin
            rt_run <= next_rt_run;
            rsp_timeout_event <= next_to_evt;
            for (int i = 0; i < 4; i++) begin
                pre_cnt[i] <= next_pre_cnt[i];
                rt_cnt[i] <= next_rt_cnt[i];
            end
        end
    end
endmodule : plr_port_ctl

// *** hw/plr_pkg.sv ***
// package for the port control and link request register bank
// assumes a 32-bit plain register port and four serial ports
package plr_pkg;
    localparam int unsigned num_ports = 4;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] off_prescale = 8'h20;
    localparam logic [7:0] off_rsp_timeout = 8'h00;
    localparam logic [7:0] off_gen_ctl = 8'h04;
    localparam logic [7:0] off_lm_req0 = 8'h40;
    localparam logic [7:0] off_lm_resp0 = 8'h60;
    localparam logic [7:0] off_port_stride = 8'h08;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned rt_value_lsb = 8;
    localparam int unsigned gen_host_bit = 31;
    localparam int unsigned gen_master_bit = 30;
    localparam int unsigned gen_disc_bit = 29;
    localparam int unsigned resp_valid_bit = 31;
    localparam int unsigned ack_lsb = 5;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [23:0] rst_rt_value = 24'hffffff;
    localparam logic [3:0] rst_prescale = 4'h0;
    localparam logic [3:0] rt_tick_mult = 4'hf;
    localparam logic [2:0] rst_command = 3'h0;

    typedef struct packed {
        logic [4:0] ack_sequence_state;
        logic [4:0] link_status;
    } plr_resp_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } plr_bus_type;
endpackage : plr_pkg

// *** verif/plr_port_ctl_assertions.sv ***
// assertions on the port control register bank
// assumes a bind into plr_port_ctl on one clock
`timescale 1ns/1ps
module plr_port_ctl_assertions (
    input wire logic clk,
    input wire logic arst_n,
    input wire plr_pkg::plr_bus_type bus,
    input wire logic [31:0] rdata,
    input wire logic host_role,
    input wire logic master_enable,
    input wire logic discovered,
    input wire logic [3:0] lreq_valid,
    input wire logic [11:0] lreq_command,
    input wire logic [3:0] lreq_ready,
    input wire logic [3:0] rsp_timeout_event
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_issue; bus.wr && bus.addr == 8'h40 |=> lreq_valid[0] && lreq_command[2:0] == $past(bus.wdata[2:0]); endproperty
    a_issue: assert property (p_issue) else $error("request not issued");
    property p_hold; lreq_valid[0] && !lreq_ready[0] |=> lreq_valid[0]; endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_once; lreq_valid[0] && lreq_ready[0] && !(bus.wr && bus.addr == 8'h40) |=> !lreq_valid[0]; endproperty
    a_once: assert property (p_once) else $error("request sent twice");
    property p_cmd; bus.rd && bus.addr == 8'h40 |=> rdata == {29'h0, lreq_command[2:0]}; endproperty
    a_cmd: assert property (p_cmd) else $error("command readback");
    property p_gen_wr; bus.wr && bus.addr == 8'h04 |=> {host_role, master_enable, discovered} == $past(bus.wdata[31:29]); endproperty
    a_gen_wr: assert property (p_gen_wr) else $error("control write");
    property p_gen_keep; !(bus.wr && bus.addr == 8'h04) |=> $stable({host_role, master_enable, discovered}); endproperty
    a_gen_keep: assert property (p_gen_keep) else $error("control changed");
    property p_gen_rd; bus.rd && bus.addr == 8'h04 |=> rdata == {host_role, master_enable, discovered, 29'h0}; endproperty
    a_gen_rd: assert property (p_gen_rd) else $error("control readback");
    property p_tmo; rsp_timeout_event[0] |=> !rsp_timeout_event[0]; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout event too long");
endmodule : plr_port_ctl_assertions
bind plr_port_ctl plr_port_ctl_assertions plr_port_ctl_assertions_i (
    .clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
    .host_role(host_role), .master_enable(master_enable), .discovered(discovered),
    .lreq_valid(lreq_valid), .lreq_command(lreq_command), .lreq_ready(lreq_ready),
    .rsp_timeout_event(rsp_timeout_event)
);

// *** verif/plr_link_model.sv ***
// link side model: takes link requests, returns link responses
// assumes one clock shared with the register bank
`timescale 1ns/1ps
module plr_link_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic [3:0] lreq_valid,
    input wire logic [11:0] lreq_command,
    output logic [3:0] lreq_ready,
    output logic [3:0] lreq_no_resp,
    output logic [3:0] lresp_valid,
    output plr_pkg::plr_resp_type [3:0] lresp
);
    logic [1:0] cnt;
    logic [3:0] pend;
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            lreq_no_resp[n] = lreq_command[n * 3 +: 3] != 3'h4;
            lresp[n] = 10'h2aa ^ 10'(n) ^ {10{!lresp_valid[n]}};
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 2'h0;
            lreq_ready <= 4'h0;
            lresp_valid <= 4'h0;
            pend <= 4'h0;
        end else begin
            cnt <= cnt + 2'h1;
            lreq_ready <= lreq_valid & ~lreq_ready & {4{!slow || cnt == 2'h3}};
            pend <= (pend & ~lresp_valid) | (lreq_valid & lreq_ready & ~lreq_no_resp);
            lresp_valid <= pend & ~lresp_valid & {4{cnt[0]}};
        end
    end
endmodule : plr_link_model

// *** verif/plr_port_ctl_test.sv ***
// bench for the port control register bank
// assumes plr_link_model on the link side
`timescale 1ns/1ps
module plr_port_ctl_test;
    logic clk = 0;
    logic arst_n = 0;
    logic slow = 0;
    plr_pkg::plr_bus_type bus = '0;
    logic [31:0] rdata;
    logic host_role, master_enable, discovered;
    logic [3:0] lreq_valid, lreq_ready, lreq_no_resp, lresp_valid, rsp_timeout_event;
    logic [3:0] pkt_req_sent = 4'h0;
    logic [3:0] pkt_resp_rcvd = 4'h0;
    logic [11:0] lreq_command;
    plr_pkg::plr_resp_type [3:0] lresp;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int k;
    plr_port_ctl plr_port_ctl_i (
        .clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
        .host_role(host_role), .master_enable(master_enable), .discovered(discovered),
        .lreq_valid(lreq_valid), .lreq_command(lreq_command), .lreq_ready(lreq_ready),
        .lreq_no_resp(lreq_no_resp), .lresp_valid(lresp_valid), .lresp(lresp),
        .pkt_req_sent(pkt_req_sent), .pkt_resp_rcvd(pkt_resp_rcvd),
        .rsp_timeout_event(rsp_timeout_event)
    );
    plr_link_model plr_link_model_i (
        .clk(clk), .arst_n(arst_n), .slow(slow),
        .lreq_valid(lreq_valid), .lreq_command(lreq_command), .lreq_ready(lreq_ready),
        .lreq_no_resp(lreq_no_resp), .lresp_valid(lresp_valid), .lresp(lresp)
    );
    always #10 clk = ~clk;
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        chk("read", rdata & m, e);
        @(posedge clk);
    endtask : rd
    task automatic send(input logic r, input int lo, input int hi);
        pkt_req_sent <= 4'h1;
        @(posedge clk);
        pkt_req_sent <= 4'h0;
        pkt_resp_rcvd <= {3'h0, r};
        @(posedge clk);
        pkt_resp_rcvd <= 4'h0;
        for (k = 2; k < 80 && rsp_timeout_event[0] !== 1'b1; k++) @(negedge clk);
        chk("timeout", 32'(k >= lo && k <= hi), 32'h1);
        @(posedge clk);
    endtask : send
    task automatic finish_test;
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(8'h00, '1, 32'hffffff00);
        rd(8'h20, '1, 32'h0);
        for (int v = 0; v < 8; v++) begin
            wr(8'h04, {v[2:0], 29'h1fffffff});
            rd(8'h04, '1, {v[2:0], 29'h0});
            chk("control", {29'h0, host_role, master_enable, discovered}, 32'(v));
        end
        for (int n = 0; n < 4; n++) begin
            for (int c = 0; c < 8; c++) begin
                slow <= c[0];
                wr(8'h40 + 8'(n * 8), 32'hfffffff8 | 32'(c));
                chk("command", 32'(lreq_command[n * 3 +: 3]), 32'(c));
                for (k = 0; k < 20 && lreq_valid[n] !== 1'b0; k++) @(negedge clk);
                for (k = 0; k < 9 && c == 4 && lresp_valid[n] !== 1'b1; k++) @(negedge clk);
                @(posedge clk);
                rd(8'h40 + 8'(n * 8), '1, 32'(c));
                rd(8'h60 + 8'(n * 8), c == 4 ? 32'h800003ff : 32'h80000000,
                    c == 4 ? {1'b1, 21'h0, 10'h2aa ^ 10'(n)} : 32'h80000000);
                rd(8'h60 + 8'(n * 8), 32'h80000000, 32'h0);
            end
        end
        wr(8'h00, 32'h200);
        wr(8'h04, 32'h0);
        send(1'b0, 80, 80);
        wr(8'h04, 32'h40000000);
        send(1'b0, 2 + 15 * 2, 2 + 15 * 2);
        send(1'b1, 80, 80);
        wr(8'h20, 32'h1);
        send(1'b0, 2 + 15 * 2 * 2, 2 + 15 * 2 * 2);
        finish_test();
    end
endmodule : plr_port_ctl_test
